// ==== idr_pkg.sv ====
/*
 * Shared constants for the device-identification responder: register
 * offsets, field positions, reset values, fixed identification words and
 * the phase enumeration.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
`default_nettype none

package idr_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_DATA = 8'h00;
   localparam logic [7:0] OFS_ERROR_FLAGS = 8'h04;
   localparam logic [7:0] OFS_COMMAND_STATUS = 8'h08;
   localparam logic [7:0] OFS_DRIVE_SELECT = 8'h0c;
   localparam logic [7:0] OFS_COMMAND_CODE = 8'h10;
   localparam logic [7:0] OFS_GEOMETRY = 8'h14;
   localparam logic [7:0] OFS_BUFFER_CONFIG = 8'h18;

   // Command codes
   localparam logic [7:0] CMD_IDENTIFY = 8'hec;

   // Drive select fields
   localparam int DSEL_ONE_HI = 7;
   localparam int DSEL_ONE_LO = 5;
   localparam int DSEL_DEVICE = 4;

   // Status bit positions
   localparam int ST_BUSY = 7;
   localparam int ST_READY = 6;
   localparam int ST_FAULT = 5;
   localparam int ST_SEEK_DONE = 4;
   localparam int ST_DATA_REQ = 3;
   localparam int ST_CORRECTED = 2;
   localparam int ST_INDEX = 1;
   localparam int ST_ERROR = 0;

   // Error bit positions
   localparam int ER_ABORTED = 2;

   // Buffer config and geometry fields
   localparam int BC_MULTI_LO = 16;
   localparam int BC_DEVICE = 24;
   localparam int GEO_HEADS_LO = 16;

   // Reset values
   localparam logic [7:0] RST_STATUS = 8'h50;
   localparam logic [7:0] RST_ERROR = 8'h00;
   localparam logic [7:0] RST_DRIVE_SELECT = 8'ha0;

   // Fixed identification words
   localparam logic [15:0] ID_WORD0 = 16'h045a;
   localparam logic [15:0] ID_WORD2 = 16'hc837;
   localparam logic [15:0] ID_SECTORS = 16'h003f;
   localparam logic [15:0] ID_CTRL_TYPE = 16'h0003;
   localparam logic [15:0] ID_ECC_BYTES = 16'h0038;
   localparam logic [7:0] ID_WORD47_HI = 8'h80;
   localparam logic [15:0] ID_WORD48 = 16'h4000;

   // Word ranges inside the sector
   localparam int W_SERIAL = 10;
   localparam int W_FIRMWARE = 23;
   localparam int W_MODEL = 27;
   localparam int SERIAL_WORDS = 10;
   localparam int FIRMWARE_WORDS = 4;
   localparam int MODEL_WORDS = 20;
   localparam logic [7:0] LAST_WORD = 8'hff;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      IDR_IDLE,
      IDR_FETCH,
      IDR_XFER
   } idr_phase_t;

endpackage : idr_pkg

`default_nettype wire

// ==== idr_responder.sv ====
/*
 * Identify-device command responder with an AXI4-Lite register port.
 * Software writes drive select and the command code; the block answers the
 * identification command with one 256-word sector read through the data
 * register, and reports completion in status and error registers.
 * Assumes one clock, synchronous active-low reset and a well-behaved master.
 */
// The AXI4-Lite slave port and the register addresses were left to the implementer.
// Summary of operation
// - Code ECh requests identification
// - One data sector returned, no parameters
// - Only aborted bit meaningful in error
// - Completion clears busy, fault, corrected
// - Word 0 classifies fixed ATA device
// - Word 1 gives default cylinder count
// - Word 2 reports no spin-up, complete
// - Word 3 low byte holds heads
// - Word 6 fixed sectors per track
// - Words 10-19 ASCII serial number
// - Word 20 controller type constant
// - Word 21 buffer size, 512-byte units
// - Word 22 fixed ECC byte count
// - Words 23-26 ASCII firmware revision
// - Words 27-46 ASCII model string
// - Word 47 high 80h, low multiple limit
// - Word 48 reads 4000h, no trusted
`timescale 1ns/10ps
`default_nettype none

module idr_responder #(
   parameter int ADDR_W = 8,
   parameter logic [15:0] DEF_CYLINDERS = 16'h3fff,
   parameter logic [7:0] DEF_HEADS = 8'h10,
   parameter logic [15:0] DEF_BUFFER_SIZE = 16'h0100,
   parameter logic [7:0] DEF_MULTI_MAX = 8'h10,
   parameter logic DEF_DEVICE = 1'b0,
   parameter logic [8*2*idr_pkg::SERIAL_WORDS-1:0] SERIAL_NUMBER = "SN000000000000000001",
   parameter logic [8*2*idr_pkg::FIRMWARE_WORDS-1:0] FIRMWARE_REV = "REV00001",
   parameter logic [8*2*idr_pkg::MODEL_WORDS-1:0] MODEL_NUMBER = "GENERIC DISK DEVICE                     "
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic data_request,
   output logic busy
);

   typedef struct packed {
      // Bus channel flags and captured write halves
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;

      // Software-visible registers
      logic [7:0] error_flags;
      logic [7:0] status;
      logic [7:0] drive_select;
      logic [15:0] cylinders;
      logic [7:0] heads;
      logic [15:0] buffer_size;
      logic [7:0] multi_max;
      logic device_id;

      // Command progress
      idr_pkg::idr_phase_t phase;
      logic [7:0] word_idx;
      logic data_request;
      logic busy;
   } idr_state_t;

   idr_state_t s;
   idr_state_t next_s;

   // Address decode shared by both channels
   // Unmapped offsets answer with an error response
   function automatic logic is_mapped(input logic [7:0] a);
      case (a)
         idr_pkg::OFS_DATA,
         idr_pkg::OFS_ERROR_FLAGS,
         idr_pkg::OFS_COMMAND_STATUS,
         idr_pkg::OFS_DRIVE_SELECT,
         idr_pkg::OFS_COMMAND_CODE,
         idr_pkg::OFS_GEOMETRY,
         idr_pkg::OFS_BUFFER_CONFIG: begin
            is_mapped = 1'b1;
         end
         default: begin
            is_mapped = 1'b0;
         end
      endcase
   endfunction : is_mapped

   // One 16-bit word of a string; first character lands in the upper byte
   // Shorter strings are zero-padded at the top by the caller
   function automatic logic [15:0] str_word(input logic [8*2*idr_pkg::MODEL_WORDS-1:0] str,
                                            input int nwords, input int k);
      int top;
      top = 16 * nwords - 1 - 16 * k;
      str_word = str[top -: 16];
   endfunction : str_word

   // Content of identification word idx
   function automatic logic [15:0] id_word(input logic [7:0] idx, input idr_state_t st);
      int i;
      i = int'(idx);
      // Words with no rule read as zero
      // Reserved words 4, 5 and 7 to 9 fall through
      id_word = 16'h0000;
      if (i == 0) begin
         id_word = idr_pkg::ID_WORD0;
      end else if (i == 1) begin
         id_word = st.cylinders;
      end else if (i == 2) begin
         id_word = idr_pkg::ID_WORD2;
      end else if (i == 3) begin
         id_word = {8'h00, st.heads};
      end else if (i == 6) begin
         id_word = idr_pkg::ID_SECTORS;
      end else if (i >= idr_pkg::W_SERIAL && i < idr_pkg::W_SERIAL + idr_pkg::SERIAL_WORDS) begin
         id_word = str_word({{(8*2*(idr_pkg::MODEL_WORDS-idr_pkg::SERIAL_WORDS)){1'b0}}, SERIAL_NUMBER},
                            idr_pkg::SERIAL_WORDS, i - idr_pkg::W_SERIAL);
      end else if (i == 20) begin
         id_word = idr_pkg::ID_CTRL_TYPE;
      end else if (i == 21) begin
         id_word = st.buffer_size;
      end else if (i == 22) begin
         id_word = idr_pkg::ID_ECC_BYTES;
      end else if (i >= idr_pkg::W_FIRMWARE && i < idr_pkg::W_FIRMWARE + idr_pkg::FIRMWARE_WORDS) begin
         id_word = str_word({{(8*2*(idr_pkg::MODEL_WORDS-idr_pkg::FIRMWARE_WORDS)){1'b0}}, FIRMWARE_REV},
                            idr_pkg::FIRMWARE_WORDS, i - idr_pkg::W_FIRMWARE);
      end else if (i >= idr_pkg::W_MODEL && i < idr_pkg::W_MODEL + idr_pkg::MODEL_WORDS) begin
         id_word = str_word(MODEL_NUMBER, idr_pkg::MODEL_WORDS, i - idr_pkg::W_MODEL);
      end else if (i == 47) begin
         id_word = {idr_pkg::ID_WORD47_HI, st.multi_max};
      end else if (i == 48) begin
         id_word = idr_pkg::ID_WORD48;
      end
   endfunction : id_word

   // Byte-lane merge for read-write registers
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
      // Lanes with a clear strobe keep their old bytes
      merge = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            merge[8*b +: 8] = d[8*b +: 8];
         end
      end
   endfunction : merge

   always_comb begin
      logic [31:0] m;
      logic [7:0] ra;
      m = 32'h0000_0000;
      ra = 8'(s_axi_araddr);
      next_s = s;

      // A channel's ready drops on take and returns only after the response,
      // so a second write cannot overtake the first
      // Write address and data are taken independently
      if (s_axi_awvalid && s.awready) begin
         next_s.awready = 1'b0;
         next_s.aw_held = 1'b1;
         next_s.aw_addr = 8'(s_axi_awaddr);
      end
      if (s_axi_wvalid && s.wready) begin
         next_s.wready = 1'b0;
         next_s.w_held = 1'b1;
         next_s.w_data = s_axi_wdata;
         next_s.w_strb = s_axi_wstrb;
      end

      // Command progress
      unique case (s.phase)
         idr_pkg::IDR_IDLE: begin
         end
         idr_pkg::IDR_FETCH: begin
            // Busy stands for exactly one cycle before data request
            // sector ready for host
            next_s.phase = idr_pkg::IDR_XFER;
            next_s.status[idr_pkg::ST_BUSY] = 1'b0;
            next_s.status[idr_pkg::ST_DATA_REQ] = 1'b1;
            next_s.word_idx = 8'h00;
         end
         idr_pkg::IDR_XFER: begin
         end
      endcase

      // Register write once both halves are held
      // Writes while a command runs are answered but dropped,
      // so the sector cannot change under the host
      if (s.aw_held && s.w_held && !s.bvalid) begin
         next_s.aw_held = 1'b0;
         next_s.w_held = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = is_mapped(s.aw_addr) ? idr_pkg::RESP_OKAY : idr_pkg::RESP_SLVERR;
         if (s.phase == idr_pkg::IDR_IDLE) begin
            if (s.aw_addr == idr_pkg::OFS_DRIVE_SELECT && s.w_strb[0]) begin
               next_s.drive_select = s.w_data[7:0];
            end
            // Geometry and buffer settings show at the next command
            if (s.aw_addr == idr_pkg::OFS_GEOMETRY) begin
               m = merge({8'h00, s.heads, s.cylinders}, s.w_data, s.w_strb);
               next_s.cylinders = m[15:0];
               next_s.heads = m[idr_pkg::GEO_HEADS_LO +: 8];
            end
            // Own device number sits in bit 24
            if (s.aw_addr == idr_pkg::OFS_BUFFER_CONFIG) begin
               m = merge({7'h00, s.device_id, s.multi_max, s.buffer_size}, s.w_data, s.w_strb);
               next_s.buffer_size = m[15:0];
               next_s.multi_max = m[idr_pkg::BC_MULTI_LO +: 8];
               next_s.device_id = m[idr_pkg::BC_DEVICE];
            end
            // A command for the other device is ignored entirely
            if (s.aw_addr == idr_pkg::OFS_COMMAND_CODE && s.w_strb[0] &&
                s.drive_select[idr_pkg::DSEL_DEVICE] == s.device_id) begin
               next_s.status[idr_pkg::ST_FAULT] = 1'b0;
               next_s.status[idr_pkg::ST_CORRECTED] = 1'b0;
               next_s.status[idr_pkg::ST_READY] = 1'b1;
               if (s.w_data[7:0] == idr_pkg::CMD_IDENTIFY) begin
                  // Fetch phase starts next cycle; the transfer opens one cycle later
                  next_s.phase = idr_pkg::IDR_FETCH;
                  next_s.status[idr_pkg::ST_BUSY] = 1'b1;
                  next_s.status[idr_pkg::ST_ERROR] = 1'b0;
                  next_s.error_flags = 8'h00;
               end else begin
                  // Ready stays set; no transfer follows
                  // only aborted bit reported
                  next_s.error_flags = 8'h00;
                  next_s.error_flags[idr_pkg::ER_ABORTED] = 1'b1;
                  next_s.status[idr_pkg::ST_ERROR] = 1'b1;
               end
            end
         end
      end
      // Response handshake reopens both write channels
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
         next_s.awready = 1'b1;
         next_s.wready = 1'b1;
      end

      // Register read
      // One read at a time; a data read during a transfer answers and advances the pointer
      if (s_axi_arvalid && s.arready) begin
         next_s.arready = 1'b0;
         next_s.rvalid = 1'b1;
         next_s.rresp = is_mapped(ra) ? idr_pkg::RESP_OKAY : idr_pkg::RESP_SLVERR;
         next_s.rdata = 32'h0000_0000;
         if (ra == idr_pkg::OFS_DATA && s.phase == idr_pkg::IDR_XFER) begin
            next_s.rdata = {16'h0000, id_word(s.word_idx, s)};
            next_s.word_idx = s.word_idx + 8'h01;
            if (s.word_idx == idr_pkg::LAST_WORD) begin
               next_s.phase = idr_pkg::IDR_IDLE;
               next_s.status[idr_pkg::ST_DATA_REQ] = 1'b0;
               next_s.status[idr_pkg::ST_BUSY] = 1'b0;
               next_s.status[idr_pkg::ST_FAULT] = 1'b0;
               next_s.status[idr_pkg::ST_CORRECTED] = 1'b0;
               next_s.status[idr_pkg::ST_READY] = 1'b1;
               next_s.status[idr_pkg::ST_ERROR] = 1'b0;
            end
         end else if (ra == idr_pkg::OFS_ERROR_FLAGS) begin
            // Only the aborted bit can be set
            next_s.rdata = {24'h000000, s.error_flags};
         end else if (ra == idr_pkg::OFS_COMMAND_STATUS) begin
            // Busy, ready, fault, data request and error
            next_s.rdata = {24'h000000, s.status};
         end else if (ra == idr_pkg::OFS_DRIVE_SELECT) begin
            next_s.rdata = {24'h000000, s.drive_select};
         end else if (ra == idr_pkg::OFS_GEOMETRY) begin
            // Heads above cylinders
            next_s.rdata = {8'h00, s.heads, s.cylinders};
         end else if (ra == idr_pkg::OFS_BUFFER_CONFIG) begin
            // Device number above limit and size
            next_s.rdata = {7'h00, s.device_id, s.multi_max, s.buffer_size};
         end
      end
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
         next_s.arready = 1'b1;
      end

      // Flag outputs follow status so both change in the same cycle
      next_s.data_request = next_s.status[idr_pkg::ST_DATA_REQ];
      next_s.busy = next_s.status[idr_pkg::ST_BUSY];
   end

   always_ff @(posedge clk) begin
      // Reset wins over the clock enable
      if (!resetn) begin
         s <= '0;
         s.awready <= 1'b1;
         s.wready <= 1'b1;
         s.arready <= 1'b1;
         s.status <= idr_pkg::RST_STATUS;
         s.error_flags <= idr_pkg::RST_ERROR;
         s.drive_select <= idr_pkg::RST_DRIVE_SELECT;
         s.cylinders <= DEF_CYLINDERS;
         s.heads <= DEF_HEADS;
         s.buffer_size <= DEF_BUFFER_SIZE;
         s.multi_max <= DEF_MULTI_MAX;
         s.device_id <= DEF_DEVICE;
         s.phase <= idr_pkg::IDR_IDLE;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // Outputs come straight from the state flops
   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign data_request = s.data_request;
   assign busy = s.busy;

endmodule : idr_responder

`default_nettype wire

// ==== idr_responder_assertions.sv ====
/* Port checks for the identify responder: bus handshakes and command phases.
   Assumes one clock, synchronous active-low reset, bound onto idr_responder. */
`timescale 1ns/10ps
`default_nettype none
module idr_responder_assertions (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic data_request,
   input wire logic busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn || !ce);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_wr_answer;
      !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   sequence s_xfer_open;
      !busy && data_request;
   endsequence
   write_answer_a: assert property (s_wr_take |=> s_wr_answer)
      else $error("write answer late or early");
   resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer missing");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   read_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read not released");
   busy_start_a: assert property ($rose(busy) |-> $rose(s_axi_bvalid))
      else $error("busy without command write");
   busy_pulse_a: assert property ($rose(busy) |=> s_xfer_open)
      else $error("transfer not opened after busy");
   drq_end_a: assert property ($fell(data_request) |-> s_axi_rvalid || $past(s_axi_rvalid))
      else $error("data request ended without read");
endmodule : idr_responder_assertions
bind idr_responder idr_responder_assertions u_chk (
   .clk(clk), .resetn(resetn), .ce(ce), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .data_request(data_request), .busy(busy));
`default_nettype wire

// ==== idr_host_model.sv ====
/* Host adapter model: register writes and reads as an AXI4-Lite master.
   Assumes a slave that answers; returns 2'b11 as response on timeout. */
`timescale 1ns/10ps
`default_nettype none
module idr_host_model (
   input wire logic clk,
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   initial begin
      {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
      wstrb = 4'hf;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awvalid && awready) begin
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
            wdata <= ~d;
         end
      end while (!(bvalid && bready) && n < 100);
      r = (bvalid && bready) ? bresp : 2'b11;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arvalid && arready) begin
            arvalid <= 1'b0;
            araddr <= ~a;
         end
      end while (!(rvalid && rready) && n < 100);
      d = rdata;
      r = (rvalid && rready) ? rresp : 2'b11;
      rready <= 1'b0;
   endtask : rd
   task automatic issue(input logic dev, input logic [7:0] code, output logic [1:0] r);
      wr(idr_pkg::OFS_DRIVE_SELECT, {24'h0, 3'b101, dev, 4'h0}, r);
      wr(idr_pkg::OFS_COMMAND_CODE, {24'h0, code}, r);
   endtask : issue
endmodule : idr_host_model
`default_nettype wire

// ==== tb_identify_device_responder.sv ====
/* Self-checking bench for the identify responder with random geometry.
   Assumes the package, design, checker and host model are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb_identify_device_responder;
   localparam logic [159:0] SN = "TB SERIAL 0042      ";
   localparam logic [63:0] FW = "FW 0.07 ";
   localparam logic [319:0] MN = "BENCH MODEL DISK                        ";
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   logic [7:0] awaddr, araddr, heads, multi, code;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [15:0] cyl, bsize;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, drq, busy;
   int err_total = 0;
   int cmp_count = 0;
   int seed = 4175;
   always #12.5 clk = ~clk;
   idr_responder #(.SERIAL_NUMBER(SN), .FIRMWARE_REV(FW), .MODEL_NUMBER(MN)) dut (
      .clk(clk), .resetn(resetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .data_request(drq), .busy(busy));
   idr_host_model host (
      .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));
   function automatic logic [15:0] exp_word(input int i);
      if (i >= 10 && i < 20) return SN[159-16*(i-10) -: 16];
      if (i >= 23 && i < 27) return FW[63-16*(i-23) -: 16];
      if (i >= 27 && i < 47) return MN[319-16*(i-27) -: 16];
      case (i)
         0: return 16'h045a;
         1: return cyl;
         2: return 16'hc837;
         3: return {8'h00, heads};
         6: return 16'h003f;
         20: return 16'h0003;
         21: return bsize;
         22: return 16'h0038;
         47: return {8'h80, multi};
         48: return 16'h4000;
         default: return 16'h0000;
      endcase
   endfunction : exp_word
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic bus_dead(input logic [1:0] rr);
      if (rr === 2'b11) begin
         err_total++;
         $display("wrong value at %0t: bus timeout", $time);
         report_and_stop();
      end
   endtask : bus_dead
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      host.rd(a, d, r);
      bus_dead(r);
      chk(d, e, "read data");
      chk({30'h0, r}, {30'h0, er}, "read response");
   endtask : rdc
   task automatic wrc(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      host.wr(a, v, r);
      bus_dead(r);
      chk({30'h0, r}, {30'h0, er}, "write response");
   endtask : wrc
   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      rdc(idr_pkg::OFS_COMMAND_STATUS, 32'h50, 2'b00);
      rdc(idr_pkg::OFS_ERROR_FLAGS, 32'h00, 2'b00);
      rdc(idr_pkg::OFS_DRIVE_SELECT, 32'ha0, 2'b00);
      rdc(idr_pkg::OFS_COMMAND_CODE, 32'h00, 2'b00);
      rdc(idr_pkg::OFS_DATA, 32'h00, 2'b00);
      rdc(8'h1c, 32'h00, 2'b10);
      wrc(8'h1c, 32'hffffffff, 2'b10);
      for (int k = 0; k < 3; k++) begin
         cyl = (k == 0) ? 16'hffff : 16'($random(seed));
         heads = 8'($random(seed));
         bsize = 16'($random(seed));
         multi = (k == 0) ? 8'hff : 8'($random(seed));
         code = 8'($random(seed));
         if (code == 8'hec) code = 8'h00;
         wrc(idr_pkg::OFS_GEOMETRY, {8'h00, heads, cyl}, 2'b00);
         wrc(idr_pkg::OFS_BUFFER_CONFIG, {8'h00, multi, bsize}, 2'b00);
         // Unknown code aborts, then other device ignores identify
         host.issue(1'b0, code, r);
         rdc(idr_pkg::OFS_ERROR_FLAGS, 32'h04, 2'b00);
         host.issue(1'b1, 8'hec, r);
         rdc(idr_pkg::OFS_COMMAND_STATUS, 32'h51, 2'b00);
         host.issue(1'b0, 8'hec, r);
         rdc(idr_pkg::OFS_COMMAND_STATUS, 32'h58, 2'b00);
         rdc(idr_pkg::OFS_ERROR_FLAGS, 32'h00, 2'b00);
         chk({31'h0, drq}, 32'h1, "data request");
         // Config write in mid-transfer must not reach the sector
         wrc(idr_pkg::OFS_GEOMETRY, {8'h00, ~heads, ~cyl}, 2'b00);
         for (int i = 0; i < 256; i++) begin
            rdc(idr_pkg::OFS_DATA, {16'h0, exp_word(i)}, 2'b00);
         end
         rdc(idr_pkg::OFS_COMMAND_STATUS, 32'h50, 2'b00);
         chk({30'h0, drq, busy}, 32'h0, "idle flags");
         rdc(idr_pkg::OFS_DATA, 32'h00, 2'b00);
      end
      // Frozen clock enable keeps the transfer in place
      host.issue(1'b0, 8'hec, r);
      rdc(idr_pkg::OFS_DATA, {16'h0, exp_word(0)}, 2'b00);
      ce <= 1'b0;
      repeat (6) @(posedge clk);
      chk({30'h0, drq, busy}, 32'h2, "frozen flags");
      ce <= 1'b1;
      rdc(idr_pkg::OFS_DATA, {16'h0, exp_word(1)}, 2'b00);
      // Reset in mid-transfer wins over a low clock enable
      resetn <= 1'b0;
      ce <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      ce <= 1'b1;
      chk({30'h0, drq, busy}, 32'h0, "flags after reset");
      rdc(idr_pkg::OFS_COMMAND_STATUS, 32'h50, 2'b00);
      rdc(idr_pkg::OFS_DATA, 32'h00, 2'b00);
      report_and_stop();
   end
endmodule : tb_identify_device_responder
`default_nettype wire
